/* core/niac_top.sv */
// Interrupt action engine: config register, event capture, message issue
// Notes on behaviour
// - Doorbell action lives in bits 14:12
// - Peer reset action lives in bits 17:15
// - Peer power action lives in bits 20:18
// - Act on set; INTx also on clear
// - Code zero masks the event entirely
// - Code one sends an MSI
// - Codes two..five: INTA..INTD assert/negate
// - MSI only while MSI enable set
// - INTx suppressed while legacy disable set
// - Codes six and seven send nothing; their edges set the reserved status bit
// - MSI carries traffic class bits 31:29
// - Traffic class value used directly
// - Same encoding for message fields; reset zero
module niac_top #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [niac_pkg::NIAC_NUM_EVT-1:0] irq_event_flags,
    input wire logic msi_enable,
    input wire logic legacy_irq_disable,
    output logic msg_valid,
    input wire logic msg_ready,
    output niac_pkg::niac_msg_s msg,
    output logic irq
);
    import niac_pkg::*;

    // ==========================================================
    // Storage
    // ==========================================================
    logic [31:0] cfg; // interrupt_action_config
    logic [NIAC_ST_W-1:0] status; // Sticky events
    logic [NIAC_ST_W-1:0] mask; // Interrupt enables
    niac_state_e state; // Issue engine
    logic [NIAC_NUM_EVT-1:0] pend_set; // Set-edge requests
    logic [NIAC_NUM_EVT-1:0] pend_clr; // Clear-edge requests
    logic [NIAC_NUM_EVT-1:0] ack_set;
    logic [NIAC_NUM_EVT-1:0] ack_clr;
    logic [NIAC_NUM_EVT-1:0] rsvd_hit;
    logic [2:0] act [NIAC_NUM_EVT]; // Action field per event

    // ==========================================================
    // Bus front end
    // ==========================================================
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic [1:0] wr_resp;
    logic [1:0] rd_resp;

    niac_axil_if #(.ADDR_W(ADDR_W)) u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_resp(wr_resp),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_resp(rd_resp)
    );

    // ==========================================================
    // Address decode
    // ==========================================================
    wire wa_cfg = (wr_addr == ADDR_W'(NIAC_OFS_CFG));
    wire wa_status = (wr_addr == ADDR_W'(NIAC_OFS_STATUS));
    wire wa_mask = (wr_addr == ADDR_W'(NIAC_OFS_MASK));
    wire wa_state = (wr_addr == ADDR_W'(NIAC_OFS_STATE));
    wire ra_cfg = (rd_addr == ADDR_W'(NIAC_OFS_CFG));
    wire ra_status = (rd_addr == ADDR_W'(NIAC_OFS_STATUS));
    wire ra_mask = (rd_addr == ADDR_W'(NIAC_OFS_MASK));
    wire ra_state = (rd_addr == ADDR_W'(NIAC_OFS_STATE));
    // Unmapped answers SLVERR; the read-only state word ignores writes
    assign wr_resp = (wa_cfg | wa_status | wa_mask | wa_state) ? NIAC_RESP_OKAY : NIAC_RESP_SLVERR;
    assign rd_resp = (ra_cfg | ra_status | ra_mask | ra_state) ? NIAC_RESP_OKAY : NIAC_RESP_SLVERR;
    wire [31:0] lane_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire [31:0] wbits = lane_mask & NIAC_CFG_WMASK;
    wire [31:0] next_cfg = (cfg & ~wbits) | (wr_data & wbits);
    wire low_lane = wr_en & wr_strb[0];
    wire [NIAC_ST_W-1:0] w1c = (low_lane & wa_status) ? wr_data[NIAC_ST_W-1:0] : '0;
    wire [31:0] state_word = {10'h000, state == NIAC_ST_SEND, pend_clr, pend_set, irq_event_flags};
    // Narrow registers sit in the low bits, the rest reads zero
    assign rd_data = ra_cfg ? cfg :
                     ra_status ? {29'h00000000, status} :
                     ra_mask ? {29'h00000000, mask} :
                     ra_state ? state_word : 32'h00000000;

    // ==========================================================
    // Event units; message fields, doorbell and peers share one encoding
    // ==========================================================
    for (genvar i = 0; i < NIAC_NUM_EVT; i++)
    begin : g_evt
        assign act[i] = cfg[NIAC_ACT_W*i +: NIAC_ACT_W];
        niac_evt_unit u_evt (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .flag(irq_event_flags[i]),
            .action(act[i]),
            .ack_set(ack_set[i]),
            .ack_clr(ack_clr[i]),
            .pend_set(pend_set[i]),
            .pend_clr(pend_clr[i]),
            .rsvd_hit(rsvd_hit[i])
        );
    end

    // ==========================================================
    // Fixed priority pick, lowest index first, set before clear
    // ==========================================================
    logic [2:0] sel_idx;
    logic sel_clr;
    always_comb
    begin
        sel_idx = 3'h0;
        sel_clr = 1'b0;
        for (int i = NIAC_NUM_EVT - 1; i >= 0; i--)
        begin
            if (pend_set[i] || pend_clr[i])
            begin
                sel_idx = 3'(i);
                sel_clr = ~pend_set[i];
            end
        end
    end

    wire sel_any = |(pend_set | pend_clr);
    wire [2:0] sel_act = act[sel_idx];
    wire sel_msi = (sel_act == NIAC_ACT_MSI);
    wire sel_intx = (sel_act >= NIAC_ACT_INTA) && (sel_act <= NIAC_ACT_INTD);
    wire intx_ok = sel_intx & ~legacy_irq_disable;
    wire msi_ok = sel_msi & msi_enable;
    // Negation only exists for INTx; stale clears are dropped
    wire sel_ok = sel_clr ? intx_ok : (msi_ok | intx_ok);
    wire issue = ce & (state == NIAC_ST_IDLE) & sel_any;
    wire load = issue & sel_ok;
    wire drop = issue & ~sel_ok;
    wire sent = ce & msg_valid & msg_ready;

    for (genvar i = 0; i < NIAC_NUM_EVT; i++)
    begin : g_ack
        assign ack_set[i] = issue & ~sel_clr & (sel_idx == 3'(i));
        assign ack_clr[i] = issue & sel_clr & (sel_idx == 3'(i));
    end

    niac_msg_s next_msg;
    assign next_msg.kind = sel_clr ? NIAC_MSG_NEGATE : (sel_msi ? NIAC_MSG_MSI : NIAC_MSG_ASSERT);
    assign next_msg.line = 2'(sel_act - NIAC_ACT_INTA);
    assign next_msg.tc = cfg[NIAC_TC_LSB +: 3];
    assign next_msg.src = sel_idx;
    assign msg_valid = (state == NIAC_ST_SEND);

    // ==========================================================
    // Issue engine; one message in flight, held until taken
    // ==========================================================
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= NIAC_ST_IDLE;
            msg <= '0;
        end
        else if (ce)
        begin
            unique case (state)
                NIAC_ST_IDLE:
                    if (load)
                    begin
                        state <= NIAC_ST_SEND;
                        msg <= next_msg;
                    end
                NIAC_ST_SEND:
                    if (msg_ready)
                        state <= NIAC_ST_IDLE;
                default:
                    state <= NIAC_ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Registers; hardware set wins over W1C
    // ==========================================================
    wire [NIAC_ST_W-1:0] st_ev = {|rsvd_hit & ce, drop, sent};
    wire [NIAC_ST_W-1:0] next_status = (status & ~w1c) | st_ev;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg <= NIAC_CFG_RST;
            status <= '0;
            mask <= NIAC_MASK_RST;
        end
        else if (ce)
        begin
            if (wr_en && wa_cfg)
                cfg <= next_cfg;
            if (low_lane && wa_mask)
                mask <= wr_data[NIAC_ST_W-1:0];
            status <= next_status;
        end
    end

    // Level interrupt, no hidden delay
    assign irq = |(status & mask);

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_rsvd_zero: assert property (cfg[NIAC_RSVD_MSB:NIAC_RSVD_LSB] == 8'h00)
        else $error("reserved config bits not zero");
    chk_msi_gate: assert property ((issue && !sel_clr && sel_msi && !msi_enable) |=> !msg_valid)
        else $error("MSI issued while disabled");
    chk_intx_gate: assert property ((issue && sel_intx && legacy_irq_disable) |=> !msg_valid)
        else $error("INTx issued while disabled");
    chk_msi_kind: assert property ((load && !sel_clr && sel_msi) |=> (msg_valid && msg.kind == NIAC_MSG_MSI))
        else $error("MSI action wrong kind");
    chk_intx_line: assert property ((load && !sel_clr && sel_intx) |=>
        (msg.kind == NIAC_MSG_ASSERT && msg.line == 2'($past(sel_act) - NIAC_ACT_INTA)))
        else $error("INTx line wrong");
    chk_negate_kind: assert property ((load && sel_clr) |=> (msg_valid && msg.kind == NIAC_MSG_NEGATE))
        else $error("clear did not negate");
    chk_msi_class: assert property (load |=> msg.tc == $past(cfg[31:29]))
        else $error("traffic class wrong");
    chk_msg_source: assert property (load |=> msg.src == $past(sel_idx))
        else $error("message source wrong");
    chk_msg_hold: assert property ((msg_valid && !msg_ready) |=> (msg_valid && $stable(msg)))
        else $error("message dropped before taken");
    chk_reset_zero: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> cfg == 32'h00000000)
        else $error("config not zero after reset");

    cov_msi_sent: cover property (sent && msg.kind == NIAC_MSG_MSI);
    cov_assert_sent: cover property (sent && msg.kind == NIAC_MSG_ASSERT);
    cov_negate_sent: cover property (sent && msg.kind == NIAC_MSG_NEGATE);
    cov_dropped: cover property (drop);
endmodule

/* common/niac_pkg.sv */
// Shared constants, field layout and types of the interrupt action block
package niac_pkg;

    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int NIAC_NUM_EVT = 7; // Msg0..3, doorbell, peer reset, peer power
    localparam int NIAC_ACT_W = 3; // Width of one action field
    localparam int NIAC_ST_W = 3; // Sticky status bits

    // ==========================================================
    // Register offsets (byte addresses)
    // ==========================================================
    localparam logic [7:0] NIAC_OFS_CFG = 8'h00; // interrupt_action_config
    localparam logic [7:0] NIAC_OFS_STATUS = 8'h04; // Sticky event bits, W1C
    localparam logic [7:0] NIAC_OFS_MASK = 8'h08; // Interrupt mask
    localparam logic [7:0] NIAC_OFS_STATE = 8'h0C; // Live engine state, RO

    // ==========================================================
    // Field positions of interrupt_action_config
    // ==========================================================
    localparam int NIAC_DOORBELL_LSB = 12; // doorbell_action
    localparam int NIAC_PEER_RESET_LSB = 15; // peer_reset_action
    localparam int NIAC_PEER_POWER_LSB = 18; // peer_power_change_action
    localparam int NIAC_RSVD_LSB = 21; // Reserved 28:21
    localparam int NIAC_RSVD_MSB = 28;
    localparam int NIAC_TC_LSB = 29; // msi_class_select
    localparam logic [31:0] NIAC_CFG_WMASK = 32'hE01FFFFF; // Writable bits
    localparam logic [31:0] NIAC_CFG_RST = 32'h00000000; // All fields zero
    localparam logic [NIAC_ST_W-1:0] NIAC_MASK_RST = 3'h0;

    // ==========================================================
    // Action encodings
    // ==========================================================
    localparam logic [2:0] NIAC_ACT_OFF = 3'h0;
    localparam logic [2:0] NIAC_ACT_MSI = 3'h1;
    localparam logic [2:0] NIAC_ACT_INTA = 3'h2;
    localparam logic [2:0] NIAC_ACT_INTD = 3'h5;
    localparam logic [2:0] NIAC_ACT_RSVD = 3'h6; // 6 and 7 reserved

    // ==========================================================
    // Status bit positions
    // ==========================================================
    localparam int NIAC_ST_SENT = 0; // Message accepted by link
    localparam int NIAC_ST_DROP = 1; // Message suppressed by gating
    localparam int NIAC_ST_RSVD = 2; // Event hit a reserved action

    // ==========================================================
    // Bus answers
    // ==========================================================
    localparam logic [1:0] NIAC_RESP_OKAY = 2'h0;
    localparam logic [1:0] NIAC_RESP_SLVERR = 2'h2;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {
        NIAC_MSG_MSI = 2'h0,
        NIAC_MSG_ASSERT = 2'h1,
        NIAC_MSG_NEGATE = 2'h2
    } niac_kind_e;

    typedef enum logic [1:0] {
        NIAC_ST_IDLE = 2'b01,
        NIAC_ST_SEND = 2'b10
    } niac_state_e;

    typedef struct packed {
        niac_kind_e kind; // MSI, assert or negate
        logic [1:0] line; // 0..3 = INTA..INTD
        logic [2:0] tc; // Traffic class for MSI
        logic [2:0] src; // Event index
    } niac_msg_s;

endpackage

/* core/niac_evt_unit.sv */
// Edge capture of one event flag into pending set and clear requests
module niac_evt_unit
    import niac_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic flag,
    input wire logic [2:0] action,
    input wire logic ack_set,
    input wire logic ack_clr,
    output logic pend_set,
    output logic pend_clr,
    output logic rsvd_hit
);
    // ==========================================================
    // Edge decode
    // ==========================================================
    logic prev; // Flag one cycle ago
    wire rise = flag & ~prev;
    wire fall = ~flag & prev;
    wire is_msi = (action == NIAC_ACT_MSI);
    wire is_intx = (action >= NIAC_ACT_INTA) && (action <= NIAC_ACT_INTD);
    wire is_rsvd = (action >= NIAC_ACT_RSVD);
    // Off and reserved codes never reach the pending flags
    wire next_pend_set = (rise & (is_msi | is_intx)) | (pend_set & ~ack_set);
    wire next_pend_clr = (fall & is_intx) | (pend_clr & ~ack_clr);

    // ==========================================================
    // State; new edge wins over acknowledge
    // ==========================================================
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prev <= 1'b0;
            pend_set <= 1'b0;
            pend_clr <= 1'b0;
            rsvd_hit <= 1'b0;
        end
        else if (ce)
        begin
            prev <= flag;
            pend_set <= next_pend_set;
            pend_clr <= next_pend_clr;
            rsvd_hit <= (rise | fall) & is_rsvd;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    chk_off_masks: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && (flag != prev) && action == NIAC_ACT_OFF && !pend_set && !pend_clr) |=> (!pend_set && !pend_clr))
        else $error("off action produced a request");
    chk_rsvd_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && (flag != prev) && is_rsvd && !pend_set && !pend_clr) |=> (rsvd_hit && !pend_set && !pend_clr))
        else $error("reserved action not flagged");
    chk_edge_pends: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && rise && (is_msi || is_intx)) |=> pend_set)
        else $error("set edge lost");
endmodule

/* core/niac_axil_if.sv */
// AXI4-Lite slave front end: capture, one-cycle answers
module niac_axil_if #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic [1:0] wr_resp,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic [1:0] rd_resp
);
    // ==========================================================
    // Handshake decode
    // ==========================================================
    logic aw_held; // Address captured
    logic w_held; // Data captured
    assign awready = ce & ~aw_held & ~bvalid;
    assign wready = ce & ~w_held & ~bvalid;
    assign arready = ce & ~rvalid;
    assign rd_addr = araddr;
    // Either order: fire once both halves are in
    assign wr_en = ce & aw_held & w_held & ~bvalid;
    wire ar_take = arvalid & arready;

    // ==========================================================
    // Write path
    // ==========================================================
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            wr_addr <= '0;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end
        else if (ce)
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                wr_addr <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_en)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_resp;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Read path; data sampled at address acceptance
    // ==========================================================
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
        end
        else if (ce)
        begin
            if (ar_take)
            begin
                rvalid <= 1'b1;
                rdata <= rd_data;
                rresp <= rd_resp;
            end
            else if (rvalid && rready)
                rvalid <= 1'b0;
        end
    end
endmodule

/* test/niac_host_model.sv */
// Host side model that takes interrupt messages, promptly or slowly
module niac_host_model
    import niac_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stall,
    input wire logic msg_valid,
    input wire niac_pkg::niac_msg_s msg,
    output logic msg_ready,
    output niac_pkg::niac_msg_s last_msg,
    output int msg_count
);
    // ==========================================================
    // Acceptance: ready blinks while stalling, so waits get seen
    // ==========================================================
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            msg_ready <= 1'h0;
            msg_count <= 0;
            last_msg <= '0;
        end
        else
        begin
            msg_ready <= !stall || !msg_ready;
            // Taken at the edge that sees valid and ready high
            if (msg_valid && msg_ready)
            begin
                last_msg <= msg;
                msg_count <= msg_count + 1;
            end
        end
    end
endmodule

/* test/test_ntb_interrupt_action_config.sv */
// Self-checking bench of the interrupt action engine
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_ntb_interrupt_action_config import niac_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Stimulus and observation signals
    // ==========================================================
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, msg_valid, msg_ready, irq;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, resp;
    logic [6:0] flags = 7'h00;
    logic msi_en = 1'h0, xdis = 1'h0, stall = 1'h0, ce = 1'h1;
    niac_msg_s msg, last_msg;
    int msg_count, base, errors = 0, check_count = 0, cycles = 0;
    // Row: event, action, msi enable, legacy disable, class, rise msg, fall msg, status
    typedef struct packed {
        logic [2:0] evt; logic [2:0] act; logic men; logic xdis;
        logic [2:0] tc; logic rise; logic fall; logic [2:0] st;
    } niac_row_s;
    niac_row_s r;
    niac_row_s rows [12] = '{
        '{3'h4, 3'h1, 1'h1, 1'h0, 3'h5, 1'h1, 1'h0, 3'h1},
        '{3'h5, 3'h3, 1'h1, 1'h0, 3'h0, 1'h1, 1'h1, 3'h1},
        '{3'h6, 3'h5, 1'h0, 1'h0, 3'h0, 1'h1, 1'h1, 3'h1},
        '{3'h0, 3'h2, 1'h0, 1'h0, 3'h0, 1'h1, 1'h1, 3'h1},
        '{3'h4, 3'h4, 1'h0, 1'h0, 3'h0, 1'h1, 1'h1, 3'h1},
        '{3'h5, 3'h0, 1'h1, 1'h0, 3'h0, 1'h0, 1'h0, 3'h0},
        '{3'h6, 3'h6, 1'h1, 1'h0, 3'h0, 1'h0, 1'h0, 3'h4},
        '{3'h6, 3'h7, 1'h1, 1'h0, 3'h0, 1'h0, 1'h0, 3'h4},
        '{3'h4, 3'h1, 1'h0, 1'h0, 3'h2, 1'h0, 1'h0, 3'h2},
        '{3'h5, 3'h2, 1'h1, 1'h1, 3'h0, 1'h0, 1'h0, 3'h2},
        '{3'h6, 3'h1, 1'h1, 1'h1, 3'h7, 1'h1, 1'h0, 3'h1},
        '{3'h3, 3'h1, 1'h1, 1'h0, 3'h0, 1'h1, 1'h0, 3'h1}
    };
    // ==========================================================
    // Design, far-side host and clock
    // ==========================================================
    niac_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq_event_flags(flags),
        .msi_enable(msi_en), .legacy_irq_disable(xdis), .msg_valid(msg_valid), .msg_ready(msg_ready),
        .msg(msg), .irq(irq));
    niac_host_model host (.aclk(aclk), .aresetn(aresetn), .stall(stall), .msg_valid(msg_valid), .msg(msg),
        .msg_ready(msg_ready), .last_msg(last_msg), .msg_count(msg_count));
    always #2.5 aclk = ~aclk;
    // Hang guard: far beyond what the sequence needs
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            errors++;
            final_report();
        end
    end
    // ==========================================================
    // Tasks
    // ==========================================================
    // One register access; handshakes decided from values seen before the edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic aw_go, w_go, ar_go;
        {awaddr, araddr, wdata} <= {a, a, d};
        {awvalid, wvalid, bready, arvalid, rready} <= {wr, wr, wr, !wr, !wr};
        forever
        begin
            @(negedge aclk);
            {aw_go, w_go, ar_go} = {awvalid & awready, wvalid & wready, arvalid & arready};
            {resp, rd} = wr ? {bresp, 32'h0} : {rresp, rdata};
            if (wr ? bvalid : rvalid)
                break;
            @(posedge aclk);
            awvalid <= awvalid & !aw_go;
            wvalid <= wvalid & !w_go;
            arvalid <= arvalid & !ar_go;
        end
        @(posedge aclk);
        {bready, rready} <= 2'h0;
        @(posedge aclk);
    endtask
    // Room for issue plus a stalling host
    task automatic settle();
        repeat (12) @(posedge aclk);
    endtask
    task automatic check_msg(input niac_row_s x, input niac_kind_e k);
        `CHK("kind", k, last_msg.kind)
        `CHK("src", x.evt, last_msg.src)
        if (k == NIAC_MSG_MSI)
            `CHK("msi class", x.tc, last_msg.tc)
        else
            `CHK("line", x.act - 3'h2, {1'h0, last_msg.line})
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        bus(1'h1, 8'h08, 32'h7);
        foreach (rows[i])
        begin
            r = rows[i];
            {stall, msi_en, xdis} <= {i[0], r.men, r.xdis};
            bus(1'h1, 8'h00, ({29'h0, r.act} << (3 * r.evt)) | {r.tc, 29'h0});
            base = msg_count;
            flags[r.evt] <= 1'h1;
            settle();
            `CHK("rise count", base + r.rise, msg_count)
            if (r.rise)
                check_msg(r, r.act == 3'h1 ? NIAC_MSG_MSI : NIAC_MSG_ASSERT);
            flags[r.evt] <= 1'h0;
            settle();
            `CHK("fall count", base + r.rise + r.fall, msg_count)
            if (r.fall)
                check_msg(r, NIAC_MSG_NEGATE);
            `CHK("irq", r.st != 3'h0, irq)
            bus(1'h0, 8'h04, 32'h0);
            `CHK("status", {29'h0, r.st}, rd)
            bus(1'h1, 8'h04, {29'h0, r.st});
        end
        // Three events at once behind a masked interrupt and a slow host
        bus(1'h1, 8'h08, 32'h0);
        bus(1'h1, 8'h00, 32'h00049000);
        {stall, flags} <= {1'h1, 7'h70};
        base = msg_count;
        repeat (30) @(posedge aclk);
        `CHK("burst count", base + 3, msg_count)
        `CHK("burst last src", 3'h6, last_msg.src)
        `CHK("masked irq", 1'h0, irq)
        flags <= 7'h00;
        settle();
        `CHK("msi no clear msg", base + 3, msg_count)
        bus(1'h1, 8'h08, 32'h1);
        `CHK("unmasked irq", 1'h1, irq)
        bus(1'h1, 8'h04, 32'h7);
        `CHK("cleared irq", 1'h0, irq)
        // Clock enable low freezes the engine
        {ce, flags} <= {1'h0, 7'h10};
        base = msg_count;
        settle();
        `CHK("frozen", base, msg_count)
        ce <= 1'h1;
        settle();
        `CHK("thawed", base + 1, msg_count)
        flags <= 7'h00;
        // Reserved bits and an unmapped place
        bus(1'h1, 8'h00, 32'hFFFFFFFF);
        `CHK("write resp", 2'h0, resp)
        bus(1'h0, 8'h00, 32'h0);
        `CHK("reserved bits", 32'hE01FFFFF, rd)
        `CHK("read resp", 2'h0, resp)
        bus(1'h0, 8'h10, 32'h0);
        `CHK("unmapped resp", 2'h2, resp)
        // Reset in mid-run clears every field
        aresetn <= 1'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        bus(1'h0, 8'h00, 32'h0);
        `CHK("cfg after reset", 32'h0, rd)
        final_report();
    end
endmodule
